// *** rtl/tpc_pkg.sv ***
package tpc_pkg;

    // Widths
    localparam int TPC_AW = 4;
    localparam int TPC_DW = 16;
    localparam int TPC_PW = 16;
    localparam int TPC_IW = 3;

    // Register offsets
    localparam logic [TPC_AW-1:0] TPC_OFS_MODE = 4'h0;
    localparam logic [TPC_AW-1:0] TPC_OFS_CCR = 4'h1;
    localparam logic [TPC_AW-1:0] TPC_OFS_PRESC = 4'h2;
    localparam logic [TPC_AW-1:0] TPC_OFS_CNT = 4'h3;
    localparam logic [TPC_AW-1:0] TPC_OFS_CR0 = 4'h4;
    localparam logic [TPC_AW-1:0] TPC_OFS_CR1 = 4'h5;
    localparam logic [TPC_AW-1:0] TPC_OFS_STAT = 4'h6;
    localparam logic [TPC_AW-1:0] TPC_OFS_MASK = 4'h7;

    // Mode register fields
    localparam int TPC_MODE_OP_LO = 0;
    localparam int TPC_MODE_OP_HI = 1;
    localparam int TPC_MODE_OUTEN = 2;
    localparam int TPC_MODE_PPG = 3;
    localparam int TPC_MODE_OSEN = 4;
    localparam int TPC_MODE_OSTRIG = 5;
    localparam int TPC_MODE_E0_LO = 6;
    localparam int TPC_MODE_E1_LO = 8;
    localparam int TPC_MODE_W = 10;

    // Capture/compare control fields
    localparam int TPC_CCR_CR0CAP = 0;
    localparam int TPC_CCR_CSEL = 1;
    localparam int TPC_CCR_CR1CAP = 2;
    localparam int TPC_CCR_W = 3;

    // Status / mask bits
    localparam int TPC_IRQ_MC0 = 0;
    localparam int TPC_IRQ_MC1 = 1;
    localparam int TPC_IRQ_OVF = 2;

    // Reset values and count maximum
    localparam logic [TPC_MODE_W-1:0] TPC_MODE_RST = 10'h000;
    localparam logic [TPC_CCR_W-1:0] TPC_CCR_RST = 3'h0;
    localparam logic [TPC_PW-1:0] TPC_PRESC_RST = 16'h0000;
    localparam logic [TPC_DW-1:0] TPC_CR_RST = 16'h0000;
    localparam logic [TPC_DW-1:0] TPC_CNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        TPC_OP_STOP = 2'b00,
        TPC_OP_CLR_TRIG = 2'b01,
        TPC_OP_FREE = 2'b10,
        TPC_OP_CLR_MATCH = 2'b11
    } tpc_op_t;

    typedef enum logic [1:0] {
        TPC_EDGE_FALL = 2'b00,
        TPC_EDGE_RISE = 2'b01,
        TPC_EDGE_NONE = 2'b10,
        TPC_EDGE_BOTH = 2'b11
    } tpc_edge_t;

    typedef struct packed {
        logic [TPC_AW-1:0] addr;
        logic [TPC_DW-1:0] wdata;
        logic wr;
        logic rd;
    } tpc_bus_req_t;

    typedef struct packed {
        logic [TPC_MODE_W-1:0] mode;
        logic [TPC_CCR_W-1:0] ccr;
        logic [TPC_PW-1:0] presc;
        logic [TPC_PW-1:0] pre;
        logic [TPC_DW-1:0] cnt;
        logic [TPC_DW-1:0] cr0;
        logic [TPC_DW-1:0] cr1;
        logic [TPC_IW-1:0] stat;
        logic [TPC_IW-1:0] mask;
        logic [TPC_DW-1:0] rdata;
        logic run;
        logic os_act;
        logic sw_pend;
        logic out;
    } tpc_state_t;

endpackage

// *** rtl/tpc_edge_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module tpc_edge_sync
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Pin
    input wire logic pin_i,
    // Edge pulses
    output logic rise_o,
    output logic fall_o
);

    // Stage one feeds stage two only; the edge taps stages two and three
    logic meta_q;
    logic sync_q;
    logic last_q;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;

endmodule // tpc_edge_sync

`default_nettype wire

// *** rtl/tpc_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Pulse-generator mode gives a period of first compare plus one with second compare plus one high.
// - With a software one-shot trigger a valid trigger-pin edge still clears and restarts the count.
// - The counter starts as soon as the mode field is written with free-running or match clear; trigger clear-and-start waits for a trigger edge.
// - The first match after start may come up to one count clock early, never late.
// - One-shot output works only in free-running or trigger clear-and-start mode, not match clear.
// - With the source select set and both edges on the first pin, the first register never captures.
// - With the source select set, a second-pin edge does not capture but still raises interrupt zero.
module tpc_top
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire tpc_bus_req_t bus_i,
    output logic [TPC_DW-1:0] rdata_o,
    // External pins
    input wire logic trigger_capture_input_first_i,
    input wire logic capture_input_second_i,
    output logic timer_out_o,
    // Interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection of the pins

    logic ti0_rise;
    logic ti0_fall;
    logic ti1_rise;
    logic ti1_fall;

    tpc_edge_sync u_sync0 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .pin_i(trigger_capture_input_first_i),
        .rise_o(ti0_rise),
        .fall_o(ti0_fall)
    );

    tpc_edge_sync u_sync1 (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .pin_i(capture_input_second_i),
        .rise_o(ti1_rise),
        .fall_o(ti1_fall)
    );

    function automatic logic valid_edge(input logic [1:0] sel, input logic r, input logic f);
        logic v;
        v = 1'b0;
        unique case (sel)
            TPC_EDGE_FALL: v = f;
            TPC_EDGE_RISE: v = r;
            TPC_EDGE_BOTH: v = r | f;
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    tpc_state_t s_q;
    tpc_state_t s_d;

    tpc_op_t op;
    logic [1:0] e0_sel;
    logic [1:0] e1_sel;
    logic tick;
    logic trig;
    logic rev0;
    logic ti1_valid;
    logic os_mode;
    logic os_trig;
    logic match0;
    logic match1;
    logic ovf;
    logic cap0;
    logic cap1;
    logic [TPC_IW-1:0] ev;
    logic [TPC_IW-1:0] w1c;
    logic wr_mode;

    assign op = tpc_op_t'(s_q.mode[TPC_MODE_OP_HI:TPC_MODE_OP_LO]);
    assign e0_sel = s_q.mode[TPC_MODE_E0_LO+1:TPC_MODE_E0_LO];
    assign e1_sel = s_q.mode[TPC_MODE_E1_LO+1:TPC_MODE_E1_LO];

    always_comb
    begin
        s_d = s_q;
        w1c = '0;
        // Prescaler free-runs, so the first count tick after start is not aligned
        // At or above, so a smaller reload never waits for a full wrap
        tick = (s_q.pre >= s_q.presc);
        s_d.pre = tick ? '0 : s_q.pre + 16'h0001;

        trig = valid_edge(e0_sel, ti0_rise, ti0_fall);
        ti1_valid = valid_edge(e1_sel, ti1_rise, ti1_fall);
        // Reverse edge of the first pin; none when both edges are valid
        rev0 = 1'b0;
        if (e0_sel == TPC_EDGE_RISE)
        begin
            rev0 = ti0_fall;
        end
        else if (e0_sel == TPC_EDGE_FALL)
        begin
            rev0 = ti0_rise;
        end

        // One-shot only where overflow exists
        os_mode = s_q.mode[TPC_MODE_OSEN] &
            ((op == TPC_OP_FREE) || (op == TPC_OP_CLR_TRIG));
        // Pin edge triggers even when the software trigger is in use
        os_trig = os_mode & (s_q.sw_pend | trig);

        match0 = s_q.run & tick & ~s_q.ccr[TPC_CCR_CR0CAP] & (s_q.cnt == s_q.cr0);
        match1 = s_q.run & tick & ~s_q.ccr[TPC_CCR_CR1CAP] & (s_q.cnt == s_q.cr1);
        ovf = 1'b0;

        // Stop clears the count and the output, so a restart begins from zero
        if (op == TPC_OP_STOP)
        begin
            s_d.cnt = '0;
            s_d.run = 1'b0;
            s_d.out = 1'b0;
            s_d.os_act = 1'b0;
        end
        else
        begin
            if (op != TPC_OP_CLR_TRIG)
            begin
                s_d.run = 1'b1;
            end
            if (s_q.run && tick)
            begin
                if ((op == TPC_OP_CLR_MATCH) && match0)
                begin
                    s_d.cnt = '0;
                end
                else
                begin
                    s_d.cnt = s_q.cnt + 16'h0001;
                    ovf = (s_q.cnt == TPC_CNT_MAX);
                end
            end
            if (op == TPC_OP_CLR_MATCH)
            begin
                if (s_q.mode[TPC_MODE_PPG])
                begin
                    // High from count zero through the second compare
                    if (match0)
                    begin
                        s_d.out = 1'b1;
                    end
                    else if (match1)
                    begin
                        s_d.out = 1'b0;
                    end
                end
                else if (match0)
                begin
                    s_d.out = ~s_q.out;
                end
            end
            else if (s_q.os_act)
            begin
                if (match0)
                begin
                    s_d.out = 1'b0;
                    s_d.os_act = 1'b0;
                end
                else if (match1)
                begin
                    s_d.out = 1'b1;
                end
            end
            // Idle at zero until a trigger edge clears and starts the count
            if ((op == TPC_OP_CLR_TRIG) && trig)
            begin
                s_d.cnt = '0;
                s_d.run = 1'b1;
            end
            if (os_trig)
            begin
                s_d.cnt = '0;
                s_d.run = 1'b1;
                s_d.os_act = 1'b1;
                s_d.out = 1'b0;
            end
        end

        // Capture paths
        cap0 = s_q.ccr[TPC_CCR_CR0CAP] &
            (s_q.ccr[TPC_CCR_CSEL] ? rev0 : ti1_valid);
        cap1 = s_q.ccr[TPC_CCR_CR1CAP] & trig;
        ev = '0;
        // Second-pin edge still interrupts when it no longer captures
        ev[TPC_IRQ_MC0] = match0 | cap0 | (s_q.ccr[TPC_CCR_CSEL] & ti1_valid);
        ev[TPC_IRQ_MC1] = match1 | cap1;
        ev[TPC_IRQ_OVF] = ovf;

        // Register port; a trigger write is acted on one cycle later
        wr_mode = bus_i.wr && (bus_i.addr == TPC_OFS_MODE);
        s_d.sw_pend = wr_mode & bus_i.wdata[TPC_MODE_OSTRIG];
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                TPC_OFS_MODE:
                begin
                    s_d.mode = bus_i.wdata[TPC_MODE_W-1:0];
                    s_d.mode[TPC_MODE_OSTRIG] = 1'b0;
                end
                TPC_OFS_CCR: s_d.ccr = bus_i.wdata[TPC_CCR_W-1:0];
                TPC_OFS_PRESC: s_d.presc = bus_i.wdata[TPC_PW-1:0];
                // Compare writes take effect at once; safe timing is up to software
                TPC_OFS_CR0: s_d.cr0 = bus_i.wdata;
                TPC_OFS_CR1: s_d.cr1 = bus_i.wdata;
                TPC_OFS_STAT: w1c = bus_i.wdata[TPC_IW-1:0];
                TPC_OFS_MASK: s_d.mask = bus_i.wdata[TPC_IW-1:0];
                default:
                begin
                end
            endcase
        end
        // A capture beats a software write in the same cycle
        if (cap0)
        begin
            s_d.cr0 = s_q.cnt;
        end
        if (cap1)
        begin
            s_d.cr1 = s_q.cnt;
        end
        // Set wins over the clear
        s_d.stat = (s_q.stat & ~w1c) | ev;

        // Read data stand for one cycle only, zero otherwise
        s_d.rdata = '0;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                TPC_OFS_MODE: s_d.rdata = {6'h00, s_q.mode};
                TPC_OFS_CCR: s_d.rdata = {13'h0000, s_q.ccr};
                TPC_OFS_PRESC: s_d.rdata = s_q.presc;
                TPC_OFS_CNT: s_d.rdata = s_q.cnt;
                TPC_OFS_CR0: s_d.rdata = s_q.cr0;
                TPC_OFS_CR1: s_d.rdata = s_q.cr1;
                TPC_OFS_STAT: s_d.rdata = {13'h0000, s_q.stat};
                TPC_OFS_MASK: s_d.rdata = {13'h0000, s_q.mask};
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_q.mode <= TPC_MODE_RST;
            s_q.ccr <= TPC_CCR_RST;
            s_q.presc <= TPC_PRESC_RST;
            s_q.pre <= '0;
            s_q.cnt <= '0;
            s_q.cr0 <= TPC_CR_RST;
            s_q.cr1 <= TPC_CR_RST;
            s_q.stat <= '0;
            s_q.mask <= '0;
            s_q.rdata <= '0;
            s_q.run <= 1'b0;
            s_q.os_act <= 1'b0;
            s_q.sw_pend <= 1'b0;
            s_q.out <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_o = s_q.rdata;
    // The enable gates only the pin; the pulse logic keeps running
    assign timer_out_o = s_q.out & s_q.mode[TPC_MODE_OUTEN];
    // Level interrupt, held until software clears the status bit or its mask bit
    assign irq_o = |(s_q.stat & s_q.mask);

endmodule // tpc_top

`default_nettype wire

// *** tb/tpc_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_props
    import tpc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Watched ports
    input wire tpc_bus_req_t bus_i,
    input wire logic [TPC_DW-1:0] rdata_o,
    input wire logic trigger_capture_input_first_i,
    input wire logic capture_input_second_i,
    input wire logic timer_out_o,
    input wire logic irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // Software view rebuilt from writes; captures are not followed
    logic [15:0] mode_q, ccr_q, cr0_q, cr1_q, mask_q, pre_q, per_q;
    logic seen_q, rdc_q, ppg;
    assign ppg = mode_q[4:0] == 5'h0f && ccr_q[2:0] == 3'h0 && pre_q == 16'h0;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {mode_q, ccr_q, cr0_q, cr1_q, mask_q, pre_q, per_q} <= '0;
            {seen_q, rdc_q} <= '0;
        end
        else
        begin
            if (bus_i.wr)
            begin
                case (bus_i.addr)
                    TPC_OFS_MODE: mode_q <= bus_i.wdata;
                    TPC_OFS_CCR: ccr_q <= bus_i.wdata;
                    TPC_OFS_PRESC: pre_q <= bus_i.wdata;
                    TPC_OFS_CR0: cr0_q <= bus_i.wdata;
                    TPC_OFS_CR1: cr1_q <= bus_i.wdata;
                    TPC_OFS_MASK: mask_q <= bus_i.wdata;
                    default: ;
                endcase
            end
            // First pulse after start may be cut short, so only later ones count
            per_q <= $rose(timer_out_o) ? 16'h1 : per_q + 16'h1;
            seen_q <= !bus_i.wr && (seen_q || $rose(timer_out_o));
            rdc_q <= bus_i.rd && bus_i.addr == TPC_OFS_CR0 && ccr_q[1:0] == 2'h3
                && mode_q[7:6] == 2'h3;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 16'h0)
        else $error("read data outside a read");
    chk_irq_masked: assert property (mask_q[2:0] == 3'h0 |-> !irq_o)
        else $error("interrupt while all masked");
    chk_stop_out: assert property (
        mode_q[1:0] == 2'h0 && $past(mode_q[1:0]) == 2'h0 |-> !timer_out_o)
        else $error("output high while stopped");
    chk_stop_cnt: assert property (
        bus_i.rd && bus_i.addr == TPC_OFS_CNT && mode_q[1:0] == 2'h0
        && $past(mode_q[1:0]) == 2'h0 |=> rdata_o == 16'h0)
        else $error("count not zero while stopped");
    chk_cr0_kept: assert property (rdc_q |-> rdata_o == cr0_q)
        else $error("first register captured");
    chk_pin2_irq: assert property (
        $rose(capture_input_second_i) && ccr_q[1] && mask_q[0]
        && mode_q[9:8] == 2'h1 && mode_q[1:0] != 2'h0 |-> ##[1:6] irq_o)
        else $error("second pin edge gave no interrupt");
    chk_ppg_period: assert property (
        $rose(timer_out_o) && seen_q && ppg |-> per_q == cr0_q + 16'h1)
        else $error("pulse period wrong");
    chk_ppg_high: assert property (
        $fell(timer_out_o) && seen_q && ppg |-> per_q == cr1_q + 16'h1)
        else $error("pulse high time wrong");
endmodule // tpc_props
`default_nettype wire

// *** tb/tpc_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpc_pins (
    // Clock
    input wire logic mclk_i,
    // Pins
    output logic pin_a_o,
    output logic pin_b_o
);
    initial
    begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end
    // Pulse wider than the three-stage sampler, so each edge is seen once
    task automatic pulse(input bit second, input int width);
        @(posedge mclk_i);
        if (second)
            pin_b_o <= 1'b1;
        else
            pin_a_o <= 1'b1;
        repeat (width) @(posedge mclk_i);
        // Release only the own pin, so two parallel pulses never drive one pin twice
        if (second)
            pin_b_o <= 1'b0;
        else
            pin_a_o <= 1'b0;
    endtask
endmodule // tpc_pins
`default_nettype wire

// *** tb/tb_timer_pulse_capture_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_timer_pulse_capture_unit;
    import tpc_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    tpc_bus_req_t bus_i = '0;
    logic [15:0] rdata_o, q, c0, c1, w, w2;
    logic pin_a, pin_b, timer_out_o, irq_o;
    int err_total = 0;
    int compares = 0;

    always #2.5 mclk_i = ~mclk_i;

    tpc_top u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .trigger_capture_input_first_i(pin_a),
        .capture_input_second_i(pin_b), .timer_out_o(timer_out_o), .irq_o(irq_o));
    tpc_pins u_pins (.mclk_i(mclk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));

    task automatic wrap_up();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Length in input clocks of c plus one count ticks at prescaler setting p
    function automatic logic [15:0] ppg_len(input logic [15:0] c, input logic [15:0] p);
        return (c + 16'h1) * (p + 16'h1);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus_i.wr <= 1'b0;
    endtask
    // A zero mask only fetches the word into q
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus_i.rd <= 1'b0;
        #1;
        q = rdata_o;
        if (m != 16'h0)
            check(q & m, e);
    endtask
    // Wait for the output to reach v, then count the cycles it stays there
    task automatic lvl_len(input logic v, output logic [15:0] n);
        int k;
        k = 0;
        n = 16'h0;
        while (timer_out_o !== v && k < 5000)
        begin
            @(posedge mclk_i);
            #1;
            k++;
        end
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
            k++;
        end
        while (timer_out_o === v && k < 5000);
        if (k >= 5000)
        begin
            err_total++;
            wrap_up();
        end
    endtask

    initial
    begin
        void'($urandom(75));
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 9; a++)
            rd(4'(a), 16'h0, 16'hffff);
        rd(4'h8 | 4'($urandom), 16'h0, 16'hffff);
        wr(TPC_OFS_MODE, 16'h0002);
        rd(TPC_OFS_CNT, 16'h0, 16'h0);
        c0 = q;
        rd(TPC_OFS_CNT, 16'h0, 16'h0);
        check(q - c0, 16'h2);
        wr(TPC_OFS_MODE, 16'h0000);
        rd(TPC_OFS_CNT, 16'h0, 16'hffff);
        ////////////////////////////////////////////////////////////////////////
        wr(TPC_OFS_CR0, 16'h0007);
        wr(TPC_OFS_MASK, 16'h0001);
        wr(TPC_OFS_MODE, 16'h0003);
        repeat (40) @(posedge mclk_i);
        #1;
        check({15'h0, irq_o}, 16'h1);
        wr(TPC_OFS_MASK, 16'h0000);
        // Let the mask write settle before looking at the level
        #1;
        check({15'h0, irq_o}, 16'h0);
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_STAT, 16'h0007);
        wr(TPC_OFS_MASK, 16'h0007);
        rd(TPC_OFS_STAT, 16'h0, 16'hffff);
        check({15'h0, irq_o}, 16'h0);
        ////////////////////////////////////////////////////////////////////////
        for (int i = 0; i < 3; i++)
        begin
            c0 = 16'h3 + 16'($urandom % 60);
            c1 = (i == 0) ? c0 - 16'h1 : 16'h1 + 16'($urandom % (c0 - 16'h1));
            wr(TPC_OFS_MODE, 16'h0000);
            wr(TPC_OFS_PRESC, 16'(i));
            wr(TPC_OFS_CR0, c0);
            wr(TPC_OFS_CR1, c1);
            wr(TPC_OFS_MODE, 16'h000f);
            // First pulse only marks the start, whose timing may be off by a tick
            lvl_len(1'b1, w);
            lvl_len(1'b1, w);
            lvl_len(1'b0, w2);
            check(w, ppg_len(c1, 16'(i)));
            check(w + w2, ppg_len(c0, 16'(i)));
        end
        wr(TPC_OFS_PRESC, 16'h0000);
        ////////////////////////////////////////////////////////////////////////
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_CR0, 16'd30);
        wr(TPC_OFS_CR1, 16'd12);
        wr(TPC_OFS_MODE, 16'h0036);
        lvl_len(1'b1, w);
        check(w, 16'd18);
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_MODE, 16'h0055);
        fork
            u_pins.pulse(1'b0, 4);
            lvl_len(1'b1, w);
        join
        check(w, 16'd18);
        // Next start only once the running pulse is over
        wr(TPC_OFS_MODE, 16'h0075);
        lvl_len(1'b1, w);
        check(w, 16'd18);
        // One-shot request in match-clear mode leaves a plain square wave
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_MODE, 16'h0037);
        lvl_len(1'b1, w);
        check(w, 16'd31);
        ////////////////////////////////////////////////////////////////////////
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_CCR, 16'h0003);
        c0 = 16'h1 + 16'($urandom % 16'hfffe);
        wr(TPC_OFS_CR0, c0);
        wr(TPC_OFS_MASK, 16'h0001);
        wr(TPC_OFS_STAT, 16'h0007);
        wr(TPC_OFS_MODE, 16'h01c2);
        fork
            u_pins.pulse(1'b0, 4);
            u_pins.pulse(1'b1, 4);
        join
        repeat (6) @(posedge mclk_i);
        rd(TPC_OFS_CR0, c0, 16'hffff);
        rd(TPC_OFS_STAT, 16'h1, 16'h1);
        // Without the source select a second-pin edge captures; the count idles at zero
        wr(TPC_OFS_MODE, 16'h0000);
        wr(TPC_OFS_CCR, 16'h0001);
        wr(TPC_OFS_CR0, c0);
        wr(TPC_OFS_MODE, 16'h0181);
        u_pins.pulse(1'b1, 4);
        repeat (6) @(posedge mclk_i);
        rd(TPC_OFS_CR0, 16'h0, 16'hffff);
        wrap_up();
    end
endmodule // tb_timer_pulse_capture_unit

bind tpc_top tpc_props u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .trigger_capture_input_first_i(trigger_capture_input_first_i),
    .capture_input_second_i(capture_input_second_i), .timer_out_o(timer_out_o),
    .irq_o(irq_o));
`default_nettype wire
